// [wdt_rst_pkg.sv]
/*
  constants, codes and register layout of the watchdog, reset sequencer
  and power mode controller.
  assumes a 50 MHz cpu clock and a 16-bit register port.
*/
package wdt_rst_pkg;

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_SYS_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_WDT_CTRL   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_WDT_COUNT  = 4'h3;

  // system_config fields
  localparam int unsigned CFG_PDOWN_IRQ_EXIT_BIT = 1;
  localparam int unsigned CFG_BIDIR_RESET_BIT    = 5;

  // wdt control fields
  localparam int unsigned CTL_RELOAD_LSB     = 0;
  localparam int unsigned CTL_DISABLE_BIT    = 8;
  localparam int unsigned CTL_PRESCALE_BIT   = 9;

  // status fields
  localparam int unsigned ST_CAUSE_LSB       = 0;
  localparam int unsigned ST_WDT_EN_BIT      = 3;
  localparam int unsigned ST_INIT_DONE_BIT   = 4;
  localparam int unsigned ST_PM_REFUSED_BIT  = 5;
  localparam int unsigned ST_IDLE_BIT        = 8;
  localparam int unsigned ST_PDOWN_BIT       = 9;

  // reset values
  localparam logic [7:0] RELOAD_RESET   = 8'h00;
  localparam logic       PRESCALE_RESET = 1'b0;
  localparam logic       BIDIR_RESET    = 1'b0;
  localparam logic       PDEXIT_RESET   = 1'b0;
  localparam logic       RDY_SEEN_RESET = 1'b1;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned SEQ_TCL        = 1024;
  localparam int unsigned SEQ_CYCLES     = SEQ_TCL / 2;
  localparam int unsigned PRESC_LO       = 2;
  localparam int unsigned PRESC_HI       = 128;
  localparam int unsigned WDT_W          = 16;
  localparam int unsigned WDT_TMIN_NS    = 10240;
  localparam int unsigned WDT_TMIN_CYC   = (WDT_TMIN_NS * CLK_MHZ) / 1000;
  localparam int unsigned PIN_SETTLE_CYC = 3;

  // ------------------------------------------------------------------
  // codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CAUSE_NONE  = 3'b000,
    CAUSE_ASYNC = 3'b001,
    CAUSE_WARM  = 3'b010,
    CAUSE_SOFT  = 3'b011,
    CAUSE_WDT   = 3'b100
  } cause_e;

  typedef enum logic [3:0] {
    ST_RUN     = 4'b0000,
    ST_PMWAIT  = 4'b0001,
    ST_IDLE    = 4'b0010,
    ST_PDOWN   = 4'b0011,
    ST_HOLD    = 4'b0100,
    ST_DRAIN   = 4'b0101,
    ST_WDT_BUS = 4'b0110,
    ST_SEQ     = 4'b0111,
    ST_CHECK   = 4'b1000
  } state_e;

endpackage

// [watchdog_reset_power_control.sv]
/*
  watchdog timer, reset sequencer and idle/power-down control.
  assumes cpu instruction strobes and bus status come from logic on
  i_ref_clk; reset_in, vpp and ready pins are asynchronous to it.
*/
module watchdog_reset_power_control
  import wdt_rst_pkg::*;
#(
  parameter int unsigned SEQ_LEN = SEQ_CYCLES
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_clk_en,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_end_of_init_instr,
  input  wire logic              i_wdt_service,
  input  wire logic              i_soft_reset_instr,
  input  wire logic              i_idle_req,
  input  wire logic              i_pdown_req,
  input  wire logic              i_irq,
  input  wire logic              i_fast_ext_irq,
  input  wire logic              i_bootstrap_mode,
  input  wire logic              i_bus_busy,
  input  wire logic              i_bus_uses_ready,
  input  wire logic              i_bus_waits_done,
  input  wire logic              i_bus_access_end,
  input  wire logic              i_ready_enable,
  input  wire logic              i_ready_active_high,
  input  wire logic              i_int_access_busy,
  input  wire logic              i_ready_pin,
  input  wire logic              i_vpp_pin,
  input  wire logic              i_reset_in_pin,
  output logic                   o_reset_in_out,
  output logic                   o_reset_in_oe_n,
  output logic                   o_reset_out_pin,
  output logic                   o_io_enable,
  output logic                   o_cpu_reset_n,
  output logic                   o_cpu_halt,
  output logic                   o_periph_halt,
  output logic                   o_bus_abort,
  output logic                   o_hold_cancel
);

  if (SEQ_LEN < 2 || SEQ_LEN > 1024) begin : g_bad_seq_len
    $error("SEQ_LEN must lie in 2..1024");
  end
  if (256 * PRESC_LO != WDT_TMIN_CYC) begin : g_bad_tmin
    $error("shortest watchdog timeout does not match prescaler");
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic ready_act(input logic pin, input logic act_high);
    return act_high ? pin : !pin;
  endfunction

  function automatic logic core_in_reset(input state_e s);
    return (s == ST_HOLD) || (s == ST_DRAIN) || (s == ST_SEQ) || (s == ST_CHECK);
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic vpp_s1_r;
  logic vpp_s2_r;
  logic rdy_s1_r;
  logic rdy_s2_r;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      vpp_s1_r <= 1'b0;
      vpp_s2_r <= 1'b0;
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end else if (i_clk_en) begin
      vpp_s1_r <= i_vpp_pin;
      vpp_s2_r <= vpp_s1_r;
      rdy_s1_r <= i_ready_pin;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // ------------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------------
  state_e      state_r;
  state_e      state_nxt;
  logic [9:0]  cnt_r;
  logic [9:0]  cnt_nxt;
  cause_e      cause_r;
  cause_e      cause_nxt;
  logic        drive_r;
  logic        drive_nxt;
  logic        tgt_pd_r;
  logic        tgt_pd_nxt;
  logic        abort_nxt;
  logic        hcancel_nxt;
  logic        refused_set;
  logic        hw_mask;
  logic        seq_active;

  logic        rin_s1_r;
  logic        rin_s2_r;
  logic        rst_out_r;
  logic        io_en_r;
  logic        cpu_rst_n_r;

  logic [7:0]  reload_r;
  logic [7:0]  reload_nxt;
  logic        presc_sel_r;
  logic        presc_sel_nxt;
  logic        bidir_r;
  logic        bidir_nxt;
  logic        pdexit_r;
  logic        pdexit_nxt;
  logic        wdt_en_r;
  logic        wdt_en_nxt;
  logic        init_done_r;
  logic        init_done_nxt;
  logic        refused_r;
  logic        refused_nxt;
  logic        rdy_seen_r;
  logic        rdy_seen_nxt;

  logic [6:0]       presc_cnt_r;
  logic [6:0]       presc_cnt_nxt;
  logic [WDT_W-1:0] wdt_cnt_r;
  logic [WDT_W-1:0] wdt_cnt_nxt;
  logic [6:0]       presc_top;
  logic             wdt_run;
  logic             wdt_tick;
  logic             wdt_ovf;

  logic [DATA_W-1:0] rdata_nxt;
  logic              oe_n_nxt;

  assign seq_active = (state_r == ST_SEQ);

  // ------------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------------
  always_comb begin
    presc_top     = presc_sel_r ? 7'(PRESC_HI - 1) : 7'(PRESC_LO - 1);
    wdt_run       = wdt_en_r && ((state_r == ST_RUN) || (state_r == ST_PMWAIT)
                    || (state_r == ST_IDLE));
    wdt_tick      = wdt_run && (presc_cnt_r == presc_top);
    wdt_ovf       = wdt_tick && (wdt_cnt_r == {WDT_W{1'b1}})
                    && !i_wdt_service && !i_bootstrap_mode;
    presc_cnt_nxt = presc_cnt_r;
    wdt_cnt_nxt   = wdt_cnt_r;
    if (seq_active) begin
      presc_cnt_nxt = 7'h00;
      wdt_cnt_nxt   = 16'h0000;
    end else if (i_wdt_service) begin
      presc_cnt_nxt = 7'h00;
      wdt_cnt_nxt   = {reload_r, 8'h00};
    end else if (wdt_run) begin
      presc_cnt_nxt = wdt_tick ? 7'h00 : 7'(presc_cnt_r + 7'h01);
      if (wdt_tick) begin
        wdt_cnt_nxt = WDT_W'(wdt_cnt_r + 16'h0001);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      presc_cnt_r <= 7'h00;
      wdt_cnt_r   <= 16'h0000;
    end else if (i_clk_en) begin
      presc_cnt_r <= presc_cnt_nxt;
      wdt_cnt_r   <= wdt_cnt_nxt;
    end
  end

  // ------------------------------------------------------------------
  // reset and power sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    cause_nxt   = cause_r;
    drive_nxt   = drive_r;
    tgt_pd_nxt  = tgt_pd_r;
    abort_nxt   = 1'b0;
    hcancel_nxt = 1'b0;
    refused_set = 1'b0;
    // own drive of the reset input must not look like an external reset
    hw_mask     = (seq_active && drive_r) || (state_r == ST_CHECK);
    unique case (state_r)
      ST_RUN: begin
        if (i_soft_reset_instr) begin
          state_nxt = ST_DRAIN;
          cause_nxt = CAUSE_SOFT;
        end else if (wdt_ovf) begin
          state_nxt = ST_WDT_BUS;
          cause_nxt = CAUSE_WDT;
        end else if (i_idle_req || i_pdown_req) begin
          state_nxt  = ST_PMWAIT;
          tgt_pd_nxt = i_pdown_req;
        end
      end
      ST_PMWAIT: begin
        if (i_soft_reset_instr) begin
          state_nxt = ST_DRAIN;
          cause_nxt = CAUSE_SOFT;
        end else if (wdt_ovf) begin
          state_nxt = ST_WDT_BUS;
          cause_nxt = CAUSE_WDT;
        end else if (!i_bus_busy) begin
          if (i_ready_enable && !rdy_seen_r) begin
            state_nxt   = ST_RUN;
            refused_set = 1'b1;
          end else begin
            state_nxt = tgt_pd_r ? ST_PDOWN : ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (wdt_ovf) begin
          state_nxt = ST_WDT_BUS;
          cause_nxt = CAUSE_WDT;
        end else if (i_irq) begin
          state_nxt = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (pdexit_r && i_fast_ext_irq) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (rin_s2_r) begin
          state_nxt = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!i_int_access_busy) begin
          state_nxt   = ST_SEQ;
          cnt_nxt     = 10'h000;
          drive_nxt   = bidir_r || (cause_r == CAUSE_SOFT);
        end
      end
      ST_WDT_BUS: begin
        if (!i_bus_busy) begin
          state_nxt = ST_SEQ;
          cnt_nxt   = 10'h000;
          drive_nxt = bidir_r;
        end else if (i_bus_uses_ready && i_bus_waits_done
                     && !ready_act(rdy_s2_r, i_ready_active_high)) begin
          state_nxt = ST_SEQ;
          abort_nxt = 1'b1;
          cnt_nxt   = 10'h000;
          drive_nxt = bidir_r;
        end
      end
      ST_SEQ: begin
        cnt_nxt = 10'(cnt_r + 10'h001);
        if (cnt_r == 10'(SEQ_LEN - 1)) begin
          state_nxt = ST_CHECK;
          cnt_nxt   = 10'h000;
          drive_nxt = 1'b0;
        end
      end
      ST_CHECK: begin
        if (cnt_r != 10'(PIN_SETTLE_CYC - 1)) begin
          cnt_nxt = 10'(cnt_r + 10'h001);
        end else if (rin_s2_r) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
    if (!rin_s2_r && !hw_mask) begin
      state_nxt   = ST_HOLD;
      cause_nxt   = vpp_s2_r ? CAUSE_WARM : CAUSE_ASYNC;
      drive_nxt   = 1'b0;
      abort_nxt   = 1'b0;
      hcancel_nxt = 1'b0;
    end
    // holds and bus stay cancelled for every cycle spent draining
    hcancel_nxt = (state_nxt == ST_DRAIN);
    abort_nxt   = abort_nxt || hcancel_nxt;
    oe_n_nxt = !((state_nxt == ST_SEQ) && drive_nxt);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_r         <= ST_HOLD;
      cnt_r           <= 10'h000;
      cause_r         <= CAUSE_ASYNC;
      drive_r         <= 1'b0;
      tgt_pd_r        <= 1'b0;
      o_bus_abort     <= 1'b0;
      o_hold_cancel   <= 1'b0;
      o_reset_in_oe_n <= 1'b1;
      o_reset_in_out  <= 1'b0;
      o_cpu_halt      <= 1'b0;
      o_periph_halt   <= 1'b0;
    end else if (i_clk_en) begin
      state_r         <= state_nxt;
      cnt_r           <= cnt_nxt;
      cause_r         <= cause_nxt;
      drive_r         <= drive_nxt;
      tgt_pd_r        <= tgt_pd_nxt;
      o_bus_abort     <= abort_nxt;
      o_hold_cancel   <= hcancel_nxt;
      o_reset_in_oe_n <= oe_n_nxt;
      o_reset_in_out  <= 1'b0;
      o_cpu_halt      <= (state_nxt == ST_IDLE) || (state_nxt == ST_PDOWN);
      o_periph_halt   <= (state_nxt == ST_PDOWN);
    end
  end

  // ------------------------------------------------------------------
  // reset entry without clock
  // ------------------------------------------------------------------
  // a low reset input clears these at once; release passes two stages
  always_ff @(posedge i_ref_clk or negedge i_reset_in_pin) begin
    if (!i_reset_in_pin) begin
      rin_s1_r    <= 1'b0;
      rin_s2_r    <= 1'b0;
      rst_out_r   <= 1'b0;
      io_en_r     <= 1'b0;
      cpu_rst_n_r <= 1'b0;
    end else if (!i_resetn) begin
      rin_s1_r    <= 1'b0;
      rin_s2_r    <= 1'b0;
      rst_out_r   <= 1'b0;
      io_en_r     <= 1'b0;
      cpu_rst_n_r <= 1'b0;
    end else if (i_clk_en) begin
      rin_s1_r    <= 1'b1;
      rin_s2_r    <= rin_s1_r;
      rst_out_r   <= !core_in_reset(state_nxt) && (state_nxt != ST_WDT_BUS);
      io_en_r     <= !core_in_reset(state_nxt);
      cpu_rst_n_r <= !core_in_reset(state_nxt);
    end
  end

  assign o_reset_out_pin = rst_out_r;
  assign o_io_enable     = io_en_r;
  assign o_cpu_reset_n   = cpu_rst_n_r;

  // ------------------------------------------------------------------
  // configuration and status registers
  // ------------------------------------------------------------------
  always_comb begin
    reload_nxt    = reload_r;
    presc_sel_nxt = presc_sel_r;
    bidir_nxt     = bidir_r;
    pdexit_nxt    = pdexit_r;
    wdt_en_nxt    = wdt_en_r;
    init_done_nxt = init_done_r;
    refused_nxt   = refused_r;
    rdy_seen_nxt  = rdy_seen_r;
    if (i_wr && (i_addr == ADDR_SYS_CONFIG)) begin
      bidir_nxt  = i_wdata[CFG_BIDIR_RESET_BIT];
      pdexit_nxt = i_wdata[CFG_PDOWN_IRQ_EXIT_BIT];
    end
    if (i_wr && (i_addr == ADDR_WDT_CTRL)) begin
      reload_nxt    = i_wdata[CTL_RELOAD_LSB +: 8];
      presc_sel_nxt = i_wdata[CTL_PRESCALE_BIT];
      if (!init_done_r) begin
        wdt_en_nxt = !i_wdata[CTL_DISABLE_BIT];
      end
    end
    if (i_end_of_init_instr) begin
      init_done_nxt = 1'b1;
    end
    if (i_wr && (i_addr == ADDR_STATUS) && i_wdata[ST_PM_REFUSED_BIT]) begin
      refused_nxt = 1'b0;
    end
    if (refused_set) begin
      refused_nxt = 1'b1;
    end
    if (i_bus_access_end) begin
      rdy_seen_nxt = ready_act(rdy_s2_r, i_ready_active_high);
    end
    if (seq_active) begin
      reload_nxt    = RELOAD_RESET;
      presc_sel_nxt = PRESCALE_RESET;
      bidir_nxt     = BIDIR_RESET;
      pdexit_nxt    = PDEXIT_RESET;
      wdt_en_nxt    = 1'b1;
      init_done_nxt = 1'b0;
      rdy_seen_nxt  = RDY_SEEN_RESET;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_SYS_CONFIG: begin
          rdata_nxt[CFG_BIDIR_RESET_BIT]    = bidir_r;
          rdata_nxt[CFG_PDOWN_IRQ_EXIT_BIT] = pdexit_r;
        end
        ADDR_WDT_CTRL: begin
          rdata_nxt[CTL_RELOAD_LSB +: 8]  = reload_r;
          rdata_nxt[CTL_DISABLE_BIT]      = !wdt_en_r;
          rdata_nxt[CTL_PRESCALE_BIT]     = presc_sel_r;
        end
        ADDR_STATUS: begin
          rdata_nxt[ST_CAUSE_LSB +: 3]   = cause_r;
          rdata_nxt[ST_WDT_EN_BIT]       = wdt_en_r;
          rdata_nxt[ST_INIT_DONE_BIT]    = init_done_r;
          rdata_nxt[ST_PM_REFUSED_BIT]   = refused_r;
          rdata_nxt[ST_IDLE_BIT]         = (state_r == ST_IDLE);
          rdata_nxt[ST_PDOWN_BIT]        = (state_r == ST_PDOWN);
        end
        ADDR_WDT_COUNT: begin
          rdata_nxt = wdt_cnt_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      reload_r    <= RELOAD_RESET;
      presc_sel_r <= PRESCALE_RESET;
      bidir_r     <= BIDIR_RESET;
      pdexit_r    <= PDEXIT_RESET;
      wdt_en_r    <= 1'b1;
      init_done_r <= 1'b0;
      refused_r   <= 1'b0;
      rdy_seen_r  <= RDY_SEEN_RESET;
      o_rdata     <= '0;
    end else if (i_clk_en) begin
      reload_r    <= reload_nxt;
      presc_sel_r <= presc_sel_nxt;
      bidir_r     <= bidir_nxt;
      pdexit_r    <= pdexit_nxt;
      wdt_en_r    <= wdt_en_nxt;
      init_done_r <= init_done_nxt;
      refused_r   <= refused_nxt;
      rdy_seen_r  <= rdy_seen_nxt;
      o_rdata     <= rdata_nxt;
    end
  end

endmodule

// [wdt_rst_checker.sv]
/* assertions on the reset and power pins of the block.
   bound to every instance of its top module. */
module wdt_rst_checker #(
  parameter int unsigned SEQ_LEN = 512
) (
  input wire logic i_ref_clk, i_resetn, i_clk_en, i_irq, i_fast_ext_irq,
  input wire logic i_soft_reset_instr, i_reset_in_pin, o_reset_in_oe_n,
  input wire logic o_reset_out_pin, o_io_enable, o_cpu_reset_n, o_cpu_halt,
  input wire logic o_periph_halt, o_bus_abort, o_hold_cancel
);
  // ----
  // cycles of own pin drive
  // ----
  logic [10:0] drv_r, drv_nxt;
  always_comb drv_nxt = o_reset_in_oe_n ? 11'h000 : drv_r + 11'h001;
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) drv_r <= 11'h000;
    else if (i_clk_en) drv_r <= drv_nxt;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // ----
  // properties
  // ----
  a_seq_drive_len: assert property ($rose(o_reset_in_oe_n) |-> 32'(drv_r) == SEQ_LEN)
    else $error("pin drive length wrong");
  a_drive_in_reset: assert property (!o_reset_in_oe_n |-> !o_reset_out_pin && !o_cpu_reset_n)
    else $error("pin driven outside reset");
  a_pin_entry: assert property (!i_reset_in_pin && o_reset_in_oe_n |->
    !o_io_enable && !o_reset_out_pin && !o_cpu_reset_n)
    else $error("reset pin low without reset");
  a_drain_abort: assert property (o_hold_cancel |-> o_bus_abort)
    else $error("drain without bus abort");
  a_soft_drain: assert property (i_soft_reset_instr && i_clk_en && o_reset_out_pin &&
    !o_cpu_halt |=> o_hold_cancel)
    else $error("soft reset not taken");
  a_pdown_halts: assert property (o_periph_halt |-> o_cpu_halt)
    else $error("cpu runs in power-down");
  a_idle_exit: assert property (o_cpu_halt && !o_periph_halt && i_irq && i_clk_en |->
    ##[1:3] !o_cpu_halt)
    else $error("idle kept on interrupt");
  a_pdown_stays: assert property (o_periph_halt && o_io_enable && !i_fast_ext_irq &&
    !$past(i_fast_ext_irq) ##1 i_reset_in_pin && !i_fast_ext_irq |-> o_periph_halt)
    else $error("power-down left without cause");
  cover property ($rose(o_reset_in_oe_n));
  cover property (o_periph_halt && i_fast_ext_irq);
  cover property (o_cpu_halt && i_irq);
endmodule

bind watchdog_reset_power_control wdt_rst_checker #(.SEQ_LEN(SEQ_LEN)) i_chk (
  .i_ref_clk          (i_ref_clk),
  .i_resetn           (i_resetn),
  .i_clk_en           (i_clk_en),
  .i_irq              (i_irq),
  .i_fast_ext_irq     (i_fast_ext_irq),
  .i_soft_reset_instr (i_soft_reset_instr),
  .i_reset_in_pin     (i_reset_in_pin),
  .o_reset_in_oe_n    (o_reset_in_oe_n),
  .o_reset_out_pin    (o_reset_out_pin),
  .o_io_enable        (o_io_enable),
  .o_cpu_reset_n      (o_cpu_reset_n),
  .o_cpu_halt         (o_cpu_halt),
  .o_periph_halt      (o_periph_halt),
  .o_bus_abort        (o_bus_abort),
  .o_hold_cancel      (o_hold_cancel)
);

// [board_rst_model.sv]
/* board side of the block: pulled-up reset line and ready pin.
   assumes the bench commands external pulls and ready levels. */
module board_rst_model (
  input  wire logic i_oe_n,
  input  wire logic i_push,
  input  wire logic i_rdy_on,
  output wire logic o_pin,
  output wire logic o_rdy
);
  // open-drain line with pull-up, low while either party pulls
  assign o_pin = i_oe_n & ~i_push;
  // ready is active low on this board
  assign o_rdy = ~i_rdy_on;
endmodule

// [watchdog_reset_power_control_tb.sv]
/* self-checking bench of the watchdog, reset and power modes.
   assumes the checker and board model are compiled before it. */
module watchdog_reset_power_control_tb import wdt_rst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // wiring
  // ----
  logic i_ref_clk, i_resetn, i_clk_en, i_wr, i_rd, i_end_of_init_instr, i_wdt_service;
  logic i_soft_reset_instr, i_idle_req, i_pdown_req, i_irq, i_fast_ext_irq, i_bootstrap_mode;
  logic i_bus_busy, i_bus_uses_ready, i_bus_waits_done, i_bus_access_end, i_ready_enable;
  logic i_ready_active_high, i_int_access_busy, i_ready_pin, i_vpp_pin, i_reset_in_pin;
  logic o_reset_in_out, o_reset_in_oe_n, o_reset_out_pin, o_io_enable, o_cpu_reset_n;
  logic o_cpu_halt, o_periph_halt, o_bus_abort, o_hold_cancel, push, rdy_on;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  int miscompares, n_compared, cyc, n;
  logic [35:0] rows [4] = '{{4'h1, 16'h02FF, 16'h02FF}, {4'h0, 16'h0022, 16'h0022},
                           {4'hF, 16'hFFFF, 16'h0000}, {4'h1, 16'h0000, 16'h0000}};
  watchdog_reset_power_control #(.SEQ_LEN(16)) i_dut (.*);
  board_rst_model i_board (.i_oe_n(o_reset_in_oe_n), .i_push(push), .i_rdy_on(rdy_on),
                           .o_pin(i_reset_in_pin), .o_rdy(i_ready_pin));
  always #10 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ----
  // tasks
  // ----
  task automatic tk(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    tk(1);
    i_wr <= 1'b0;
    tk(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    i_addr <= a;
    i_rd <= 1'b1;
    tk(1);
    i_rd <= 1'b0;
    chk((o_rdata & m) === e, "read data");
    tk(1);
  endtask
  task automatic wait_run;
    tk(4);
    n = 0;
    while (o_cpu_reset_n !== 1'b1 && n < 2000) begin
      tk(1);
      n++;
    end
    chk(o_cpu_reset_n === 1'b1, "cpu kept in reset");
  endtask
  task automatic final_report;
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    {i_ref_clk, i_resetn, i_wr, i_rd, i_end_of_init_instr, i_wdt_service, push} = '0;
    {i_soft_reset_instr, i_idle_req, i_pdown_req, i_irq, i_fast_ext_irq, i_bootstrap_mode} = '0;
    {i_bus_busy, i_bus_uses_ready, i_bus_waits_done, i_bus_access_end, i_ready_enable} = '0;
    {i_ready_active_high, i_int_access_busy, i_vpp_pin, i_addr, i_wdata} = '0;
    {i_clk_en, rdy_on} = 2'h3;
    tk(2);
    i_resetn <= 1'b1;
    wait_run();
    rd(ADDR_WDT_CTRL, 16'h0000, 16'hFFFF);
    foreach (rows[i]) begin
      wr(rows[i][35:32], rows[i][31:16]);
      rd(rows[i][35:32], rows[i][15:0], 16'hFFFF);
    end
    wr(ADDR_WDT_CTRL, 16'h0100);
    rd(ADDR_STATUS, 16'h0000, 16'h0008);
    wr(ADDR_WDT_CTRL, 16'h0000);
    i_end_of_init_instr <= 1'b1;
    tk(1);
    i_end_of_init_instr <= 1'b0;
    wr(ADDR_WDT_CTRL, 16'h0100);
    rd(ADDR_STATUS, 16'h0018, 16'h0018);
    i_bus_busy <= 1'b1;
    i_idle_req <= 1'b1;
    tk(1);
    i_idle_req <= 1'b0;
    tk(4);
    chk(o_cpu_halt === 1'b0, "idle with bus busy");
    i_bus_busy <= 1'b0;
    tk(4);
    chk(o_cpu_halt === 1'b1 && o_periph_halt === 1'b0, "no idle");
    i_irq <= 1'b1;
    tk(4);
    chk(o_cpu_halt === 1'b0, "idle kept");
    {i_irq, i_ready_enable, rdy_on} <= 3'h2;
    tk(3);
    i_bus_access_end <= 1'b1;
    tk(1);
    {i_bus_access_end, i_idle_req} <= 2'h1;
    tk(1);
    i_idle_req <= 1'b0;
    tk(4);
    rd(ADDR_STATUS, 16'h0020, 16'h0120);
    {i_ready_enable, rdy_on} <= 2'h1;
    wr(ADDR_SYS_CONFIG, 16'h0002);
    i_pdown_req <= 1'b1;
    tk(1);
    {i_pdown_req, i_irq} <= 2'h1;
    tk(6);
    chk(o_periph_halt === 1'b1 && o_cpu_halt === 1'b1, "power-down left");
    i_fast_ext_irq <= 1'b1;
    tk(4);
    chk(o_periph_halt === 1'b0, "power-down kept");
    {i_irq, i_fast_ext_irq, i_bootstrap_mode} <= 3'h1;
    wr(ADDR_STATUS, 16'h0020);
    rd(ADDR_STATUS, 16'h0000, 16'h0020);
    wr(ADDR_WDT_CTRL, 16'h00FF);
    i_wdt_service <= 1'b1;
    tk(1);
    i_wdt_service <= 1'b0;
    tk(600);
    chk(o_reset_out_pin === 1'b1, "reset in loader mode");
    // busy bus waiting on a ready that stays inactive: overflow must abort it
    {i_bootstrap_mode, i_bus_busy, i_bus_uses_ready, i_bus_waits_done, rdy_on} <= 5'h0E;
    wr(ADDR_SYS_CONFIG, 16'h0020);
    i_wdt_service <= 1'b1;
    tk(1);
    i_wdt_service <= 1'b0;
    n = 0;
    while (o_reset_out_pin === 1'b1 && n < 1000) begin
      tk(1);
      n++;
    end
    chk(n == WDT_TMIN_CYC, "overflow time");
    tk(1);
    chk(o_bus_abort === 1'b1 && o_hold_cancel === 1'b0, "bus not aborted");
    {i_bus_busy, rdy_on} <= 2'h1;
    wait_run();
    rd(ADDR_STATUS, 16'h0004, 16'h0007);
    rd(ADDR_SYS_CONFIG, 16'h0000, 16'h0020);
    i_soft_reset_instr <= 1'b1;
    tk(1);
    i_soft_reset_instr <= 1'b0;
    chk(o_hold_cancel === 1'b1 && o_bus_abort === 1'b1, "no drain");
    tk(2);
    chk(!o_reset_in_oe_n && !i_reset_in_pin && !o_reset_in_out, "pin not driven");
    wait_run();
    rd(ADDR_STATUS, 16'h0003, 16'h0007);
    i_vpp_pin <= 1'b1;
    tk(3);
    push <= 1'b1;
    #1;
    chk(o_io_enable === 1'b0 && o_reset_out_pin === 1'b0, "async entry");
    tk(5);
    push <= 1'b0;
    wait_run();
    rd(ADDR_STATUS, 16'h0002, 16'h0007);
    final_report();
  end
endmodule
